// ==== qdac_pkg.sv ====
// qdac_pkg: register map, field positions, widths and timing figures of the
// quad dac update control block; shared by the design and its test bench.
package qdac_pkg;
  // widths
  localparam int NUM_CH = 4;
  localparam int DAC_BITS = 12;
  localparam int TEMP_BITS = 10;
  localparam int REG_BITS = 8;
  localparam int CH_IDX_BITS = 2;
  // register offsets
  localparam logic [7:0] ADDR_DAC_FIRST = 8'h10;
  localparam logic [7:0] ADDR_DAC_LAST = 8'h17;
  localparam logic [7:0] ADDR_CONTROL_CONFIG_THREE = 8'h1a;
  localparam logic [7:0] ADDR_DAC_CONFIGURATION = 8'h1b;
  localparam logic [7:0] ADDR_LOAD_CONFIGURATION = 8'h1c;
  localparam logic [7:0] ADDR_INTERNAL_TEMP_OFFSET = 8'h21;
  localparam logic [7:0] ADDR_EXTERNAL_TEMP_OFFSET = 8'h22;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [DAC_BITS-1:0] DAC_RESET = 12'h000;
  // control_config_three fields
  localparam int THERMAL_RES_SELECT = 1;
  localparam int LOAD_SOURCE_SELECT = 3;
  localparam int THERMAL_OUT_A_EN = 5;
  localparam int THERMAL_OUT_B_EN = 6;
  // dac_configuration fields: gain bits sit at 0..3, span bits alias 0 and 1
  localparam int GAIN_LSB = 0;
  localparam int SPAN_DOUBLE_A = 0;
  localparam int SPAN_DOUBLE_B = 1;
  localparam int LOAD_PAIR_AB = 4;
  localparam int LOAD_PAIR_CD = 5;
  localparam int UNBUF_REF_PAIR_ONE = 6;
  localparam int UNBUF_REF_PAIR_TWO = 7;
  // load_configuration fields: bits 0..3 load one channel each
  localparam int LOAD_CH_LSB = 0;
  localparam int INTERNAL_REF_SELECT = 4;
  localparam int POWER_DOWN = 5;
  // offset register sign
  localparam int OFFSET_SIGN_BIT = 7;
  // timing: least low time of the load strobe, kept by the host
  localparam int CLK_PERIOD_NS = 50;
  localparam int LOAD_LOW_MIN_NS = 20;
  localparam int LOAD_LOW_MIN_CYC_RAW = (LOAD_LOW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOAD_LOW_MIN_CYC = (LOAD_LOW_MIN_CYC_RAW < 1) ? 1 : LOAD_LOW_MIN_CYC_RAW;
endpackage

// ==== qdac_update_control.sv ====
// qdac_update_control: double-buffered four channel dac code registers,
// load command decoding, configuration and thermal output tracking.
// assumes the serial front end delivers one-cycle register strobes in the
// i_clk domain and that temperature results arrive with a one-cycle valid.
//
// Functional notes
// - written codes wait in an input stage; outputs not tracking temperature change only on load.
// - reading a dac data register returns the active output code.
// - loads come from strobe falling edge, dac config or load config bits.
// - codes are straight binary, 0 to 4095 on this 12-bit variant.
// - external reference by default; internal_ref_select picks internal one.
// - each reference pair is buffered unless its unbuffer bit is set.
// - dac configuration bits 0 to 3 select gain of two per channel.
// - power-down bit turns all channels off with high impedance outputs.
// - thermal enables make dac a follow internal, dac b external temperature.
// - thermal channels refresh on each new temperature result, no load needed.
// - thermal output is 8-bit at 1 degree, 10-bit at 0.25 degree when set.
// - span bits for a and b double the thermal output span.
// - range -128 to +127 degrees; output stops rising above +127.
// - 8-bit two's complement offset registers give the zero-volt temperature.
// - after reset only the strobe loads; load_source_select hands over to registers.
// - after reset all four outputs hold code zero until written and loaded.
`timescale 1ns/1ps
module qdac_update_control
  import qdac_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // register access from the serial front end
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [REG_BITS-1:0] i_reg_wdata,
  output logic [REG_BITS-1:0] o_reg_rdata,
  // external load strobe, active low
  input wire logic i_dac_load_strobe_n,
  // temperature results, signed quarter degrees
  input wire logic [TEMP_BITS-1:0] i_temp_internal,
  input wire logic i_temp_internal_valid,
  input wire logic [TEMP_BITS-1:0] i_temp_external,
  input wire logic i_temp_external_valid,
  // codes driving the four converters
  output logic [DAC_BITS-1:0] o_dac_code_a,
  output logic [DAC_BITS-1:0] o_dac_code_b,
  output logic [DAC_BITS-1:0] o_dac_code_c,
  output logic [DAC_BITS-1:0] o_dac_code_d,
  // analog controls
  output logic [NUM_CH-1:0] o_gain_double,
  output logic o_ref_input_pair_one_unbuf,
  output logic o_ref_input_pair_two_unbuf,
  output logic o_internal_ref_select,
  output logic o_power_down
);

  logic [REG_BITS-1:0] control_config_three;
  logic [REG_BITS-1:0] dac_configuration;
  logic [REG_BITS-1:0] load_configuration;
  logic [REG_BITS-1:0] internal_analog_temp_offset;
  logic [REG_BITS-1:0] external_analog_temp_offset;
  logic [DAC_BITS-1:0] input_code [NUM_CH];
  logic [DAC_BITS-1:0] active_code [NUM_CH];
  logic strobe_prev;
  logic strobe_fall;
  logic wr_dac_cfg;
  logic wr_load_cfg;
  logic dac_hit;
  logic [7:0] dac_rel;
  logic [CH_IDX_BITS-1:0] dac_idx;
  logic dac_msb;
  logic [NUM_CH-1:0] load_ch;
  logic [NUM_CH-1:0] therm_en;
  logic [NUM_CH-1:0] therm_upd;
  logic [DAC_BITS-1:0] therm_code [NUM_CH];
  logic [DAC_BITS-1:0] next_rdata;

  // thermal code: quarter degree difference, clamped both ways
  // both operands fit ten signed bits, so the difference carries two more;
  // the top bit flags underflow and the next one an overflow of the span
  function automatic logic [DAC_BITS-1:0] thermal_code(
    input logic [TEMP_BITS-1:0] temp,
    input logic [REG_BITS-1:0] offset,
    input logic hi_res
  );
    logic signed [TEMP_BITS+1:0] t_ext;
    logic signed [TEMP_BITS+1:0] o_ext;
    logic signed [TEMP_BITS+1:0] diff;
    logic [DAC_BITS-1:0] code;
    t_ext = {{2{temp[TEMP_BITS-1]}}, temp};
    o_ext = {{2{offset[OFFSET_SIGN_BIT]}}, offset, 2'b00};
    diff = t_ext - o_ext;
    if (diff[TEMP_BITS+1]) begin
      code = DAC_RESET; // below the zero-volt temperature
    end else if (diff[TEMP_BITS]) begin
      code = {DAC_BITS{1'b1}}; // saturate, output stops rising
    end else if (hi_res) begin
      code = {diff[TEMP_BITS-1:0], 2'b00}; // 0.25 degree per lsb
    end else begin
      code = {diff[TEMP_BITS-1:2], 4'h0}; // 1 degree per lsb
    end
    return code;
  endfunction

  // address decode of the dac data window: even byte low, odd byte high
  // the window test guards the index, so offsets outside never alias a channel
  always_comb begin
    dac_hit = (i_reg_addr >= ADDR_DAC_FIRST) && (i_reg_addr <= ADDR_DAC_LAST);
    dac_rel = i_reg_addr - ADDR_DAC_FIRST;
    dac_idx = dac_rel[CH_IDX_BITS:1];
    dac_msb = dac_rel[0];
    wr_dac_cfg = i_reg_wr && (i_reg_addr == ADDR_DAC_CONFIGURATION);
    wr_load_cfg = i_reg_wr && (i_reg_addr == ADDR_LOAD_CONFIGURATION);
  end

  // strobe edge detect; inputs are synchronous, 20 ns low is caught by one edge
  // history resets high so a strobe already low at release loads once at the first edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      strobe_prev <= 1'b1;
    end else begin
      strobe_prev <= i_dac_load_strobe_n;
    end
  end
  // a held-low strobe gives one load only; it must rise again to re-arm
  assign strobe_fall = strobe_prev && !i_dac_load_strobe_n;

  // load command sources, gated by the load source selection
  // register loads come from the write strobe itself, so a load bit acts once
  // per write; the stored configuration keeps the bit, but it never loads again
  always_comb begin
    load_ch = '0;
    if (!control_config_three[LOAD_SOURCE_SELECT]) begin
      load_ch = {NUM_CH{strobe_fall}};
    end else begin
      if (wr_dac_cfg && i_reg_wdata[LOAD_PAIR_AB]) begin
        load_ch[0] = 1'b1;
        load_ch[1] = 1'b1;
      end
      if (wr_dac_cfg && i_reg_wdata[LOAD_PAIR_CD]) begin
        load_ch[2] = 1'b1;
        load_ch[3] = 1'b1;
      end
      if (wr_load_cfg) begin
        load_ch = load_ch | i_reg_wdata[LOAD_CH_LSB +: NUM_CH];
      end
    end
  end

  // thermal tracking of channels a and b
  // channels c and d never track; their thermal code is a fixed zero
  always_comb begin
    therm_en = '0;
    therm_upd = '0;
    therm_en[0] = control_config_three[THERMAL_OUT_A_EN];
    therm_en[1] = control_config_three[THERMAL_OUT_B_EN];
    therm_upd[0] = therm_en[0] && i_temp_internal_valid;
    therm_upd[1] = therm_en[1] && i_temp_external_valid;
    therm_code[0] = thermal_code(i_temp_internal, internal_analog_temp_offset,
                                 control_config_three[THERMAL_RES_SELECT]);
    therm_code[1] = thermal_code(i_temp_external, external_analog_temp_offset,
                                 control_config_three[THERMAL_RES_SELECT]);
    therm_code[2] = DAC_RESET;
    therm_code[3] = DAC_RESET;
  end

  // per channel double buffer: input stage and active stage
  // bytes land independently, so a host that loads between the two halves
  // of a code sends a mixed value to the output; finish the pair first
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        input_code[c] <= DAC_RESET;
      end else if (i_reg_wr && dac_hit && (dac_idx == CH_IDX_BITS'(c))) begin
        if (dac_msb) begin
          input_code[c][DAC_BITS-1:REG_BITS] <= i_reg_wdata[DAC_BITS-REG_BITS-1:0];
        end else begin
          input_code[c][REG_BITS-1:0] <= i_reg_wdata; // held until load
        end
      end
    end
    // thermal results take priority; a load does not disturb a tracking channel
    // loads aimed at a tracking channel are dropped, not deferred
    always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        active_code[c] <= DAC_RESET;
      end else if (therm_en[c]) begin
        if (therm_upd[c]) begin
          active_code[c] <= therm_code[c];
        end
      end else if (load_ch[c]) begin
        active_code[c] <= input_code[c]; // straight binary code
      end
    end
  end

  // configuration registers
  // writes to unmapped offsets fall through the default and change nothing
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      control_config_three <= REG_RESET;
      dac_configuration <= REG_RESET;
      load_configuration <= REG_RESET;
      internal_analog_temp_offset <= REG_RESET;
      external_analog_temp_offset <= REG_RESET;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        ADDR_CONTROL_CONFIG_THREE: begin
          control_config_three <= i_reg_wdata;
        end
        ADDR_DAC_CONFIGURATION: begin
          dac_configuration <= i_reg_wdata;
        end
        ADDR_LOAD_CONFIGURATION: begin
          load_configuration <= i_reg_wdata;
        end
        ADDR_INTERNAL_TEMP_OFFSET: begin
          internal_analog_temp_offset <= i_reg_wdata;
        end
        ADDR_EXTERNAL_TEMP_OFFSET: begin
          external_analog_temp_offset <= i_reg_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read mux: data registers show the active code, never the pending one
  always_comb begin
    next_rdata = {DAC_BITS{1'b0}};
    if (dac_hit) begin
      if (dac_msb) begin
        next_rdata = {{REG_BITS{1'b0}}, active_code[dac_idx][DAC_BITS-1:REG_BITS]};
      end else begin
        next_rdata = {{(DAC_BITS-REG_BITS){1'b0}}, active_code[dac_idx][REG_BITS-1:0]};
      end
    end else begin
      case (i_reg_addr)
        ADDR_CONTROL_CONFIG_THREE: next_rdata[REG_BITS-1:0] = control_config_three;
        ADDR_DAC_CONFIGURATION: next_rdata[REG_BITS-1:0] = dac_configuration;
        ADDR_LOAD_CONFIGURATION: next_rdata[REG_BITS-1:0] = load_configuration;
        ADDR_INTERNAL_TEMP_OFFSET: next_rdata[REG_BITS-1:0] = internal_analog_temp_offset;
        ADDR_EXTERNAL_TEMP_OFFSET: next_rdata[REG_BITS-1:0] = external_analog_temp_offset;
        default: next_rdata[REG_BITS-1:0] = RD_UNMAPPED;
      endcase
    end
  end

  // read data register, updated only on a read strobe
  // holding the byte lets the serial side shift it out while loads go on
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= REG_RESET;
    end else if (i_reg_rd) begin
      o_reg_rdata <= next_rdata[REG_BITS-1:0];
    end
  end

  // converter codes, one register stage behind the active codes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_dac_code_a <= DAC_RESET;
      o_dac_code_b <= DAC_RESET;
      o_dac_code_c <= DAC_RESET;
      o_dac_code_d <= DAC_RESET;
    end else begin
      o_dac_code_a <= active_code[0];
      o_dac_code_b <= active_code[1];
      o_dac_code_c <= active_code[2];
      o_dac_code_d <= active_code[3];
    end
  end

  // gain per channel; span bits of a and b share the gain bits,
  // so a thermal channel doubles its span with the same bit
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_gain_double <= '0;
    end else begin
      o_gain_double <= dac_configuration[GAIN_LSB +: NUM_CH];
    end
  end

  // reference buffer bypass, one bit per reference pair
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_ref_input_pair_one_unbuf <= 1'b0;
      o_ref_input_pair_two_unbuf <= 1'b0;
    end else begin
      o_ref_input_pair_one_unbuf <= dac_configuration[UNBUF_REF_PAIR_ONE];
      o_ref_input_pair_two_unbuf <= dac_configuration[UNBUF_REF_PAIR_TWO];
    end
  end

  // reference choice and power-down; external reference after reset
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_internal_ref_select <= 1'b0;
      o_power_down <= 1'b0;
    end else begin
      o_internal_ref_select <= load_configuration[INTERNAL_REF_SELECT];
      o_power_down <= load_configuration[POWER_DOWN]; // analog side goes high-z
    end
  end

endmodule

// ==== qdac_host_model.sv ====
// qdac_host_model: host side of the external load strobe.
// assumes i_go is a one-cycle request raised just after a rising edge.
`timescale 1ns/1ps
module qdac_host_model (
  // clock and request
  input wire logic i_clk,
  input wire logic i_go,
  // strobe to the device, active low
  output logic o_load_strobe_n = 1'b1
);
  // one 50 ns low phase clears the 20 ns minimum; a request in the very next cycle
  // keeps the strobe low, so two back-to-back requests give a single fall
  always @(posedge i_clk) begin
    o_load_strobe_n <= #1 !i_go;
  end
endmodule

// ==== qdac_update_control_monitor.sv ====
// qdac_monitor: port level checks of the dac update control block.
// assumes it is bound to qdac_update_control and sees only its ports.
`timescale 1ns/1ps
module qdac_monitor
  import qdac_pkg::*;
(
  // clock, reset, register access and strobes
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  input wire logic [REG_BITS-1:0] i_reg_wdata,
  input wire logic [REG_BITS-1:0] o_reg_rdata,
  input wire logic i_dac_load_strobe_n,
  input wire logic i_temp_internal_valid,
  input wire logic i_temp_external_valid,
  // converter side
  input wire logic [DAC_BITS-1:0] o_dac_code_a,
  input wire logic [DAC_BITS-1:0] o_dac_code_b,
  input wire logic [DAC_BITS-1:0] o_dac_code_c,
  input wire logic [DAC_BITS-1:0] o_dac_code_d,
  input wire logic [NUM_CH-1:0] o_gain_double,
  input wire logic o_ref_input_pair_one_unbuf,
  input wire logic o_ref_input_pair_two_unbuf,
  input wire logic o_internal_ref_select,
  input wire logic o_power_down
);
  logic [7:0] cc3, dc, lc;
  logic strobe_q, cause, wr_1b, wr_1c;
  // shadow copies of the control registers, taken at the write edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cc3 <= 8'h00;
      dc <= 8'h00;
      lc <= 8'h00;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 8'h1a) cc3 <= i_reg_wdata;
      if (wr_1b) dc <= i_reg_wdata;
      if (wr_1c) lc <= i_reg_wdata;
    end
  end
  // edge detector resets high so a strobe low at release counts as a load at the first edge
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) strobe_q <= 1'b1;
    else strobe_q <= i_dac_load_strobe_n;
  end
  assign wr_1b = i_reg_wr && i_reg_addr == 8'h1b;
  assign wr_1c = i_reg_wr && i_reg_addr == 8'h1c;
  // anything allowed to move a code: strobe, register load, thermal result
  assign cause = (strobe_q && !i_dac_load_strobe_n && !cc3[3])
    || (cc3[3] && (wr_1b || wr_1c)) || (i_temp_internal_valid && cc3[5])
    || (i_temp_external_valid && cc3[6]);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence s_quiet_dc;
    !wr_1b ##1 !wr_1b;
  endsequence
  sequence s_quiet_lc;
    !wr_1c ##1 !wr_1c;
  endsequence
  a_reset_zero: assert property ($rose(i_arst_n) |->
    {o_dac_code_a, o_dac_code_b, o_dac_code_c, o_dac_code_d} == 48'h0)
    else $error("codes not zero after reset");
  a_hold_no_load: assert property (!cause |=> ##1
    $stable({o_dac_code_a, o_dac_code_b, o_dac_code_c, o_dac_code_d}))
    else $error("code moved without a load");
  a_thermal_a_hold: assert property (cc3[5] && !i_temp_internal_valid
    |=> ##1 $stable(o_dac_code_a)) else $error("thermal channel a moved");
  a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_readback_low: assert property (i_reg_rd && i_reg_addr == 8'h14
    |=> o_reg_rdata == o_dac_code_c[7:0]) else $error("bad low byte");
  a_readback_high: assert property (i_reg_rd && i_reg_addr == 8'h17
    |=> o_reg_rdata == {4'h0, o_dac_code_d[11:8]}) else $error("bad high byte");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr == 8'h30
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_dac_cfg_out: assert property (s_quiet_dc |-> o_gain_double == dc[3:0]
    && o_ref_input_pair_one_unbuf == dc[6] && o_ref_input_pair_two_unbuf == dc[7])
    else $error("gain or buffer outputs wrong");
  a_load_cfg_out: assert property (s_quiet_lc |->
    o_internal_ref_select == lc[4] && o_power_down == lc[5])
    else $error("reference or power-down output wrong");
endmodule
bind qdac_update_control qdac_monitor u_mon (
  .i_clk(i_clk),
  .i_arst_n(i_arst_n),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .o_reg_rdata(o_reg_rdata),
  .i_dac_load_strobe_n(i_dac_load_strobe_n),
  .i_temp_internal_valid(i_temp_internal_valid),
  .i_temp_external_valid(i_temp_external_valid),
  .o_dac_code_a(o_dac_code_a),
  .o_dac_code_b(o_dac_code_b),
  .o_dac_code_c(o_dac_code_c),
  .o_dac_code_d(o_dac_code_d),
  .o_gain_double(o_gain_double),
  .o_ref_input_pair_one_unbuf(o_ref_input_pair_one_unbuf),
  .o_ref_input_pair_two_unbuf(o_ref_input_pair_two_unbuf),
  .o_internal_ref_select(o_internal_ref_select),
  .o_power_down(o_power_down)
);

// ==== qdac_update_control_test.sv ====
// qdac_update_control_test: self-checking bench of the dac update block.
// assumes qdac_host_model drives the load strobe; seed fixed for repeats.
`timescale 1ns/1ps
module qdac_update_control_test
  import qdac_pkg::*;
();
  logic i_clk, i_arst_n, i_reg_wr, i_reg_rd, i_dac_load_strobe_n, go, h;
  logic i_temp_internal_valid, i_temp_external_valid;
  logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata, v;
  logic [9:0] i_temp_internal, i_temp_external;
  logic [11:0] o_dac_code_a, o_dac_code_b, o_dac_code_c, o_dac_code_d;
  logic [11:0] act [4];
  logic [11:0] inp [4];
  logic [3:0] o_gain_double;
  logic o_ref_input_pair_one_unbuf, o_ref_input_pair_two_unbuf;
  logic o_internal_ref_select, o_power_down;
  logic [31:0] seed;
  int num_errors, samples_checked, cycles;
  qdac_update_control u_dut (
    .i_clk(i_clk),
    .i_arst_n(i_arst_n),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata),
    .i_dac_load_strobe_n(i_dac_load_strobe_n),
    .i_temp_internal(i_temp_internal),
    .i_temp_internal_valid(i_temp_internal_valid),
    .i_temp_external(i_temp_external),
    .i_temp_external_valid(i_temp_external_valid),
    .o_dac_code_a(o_dac_code_a),
    .o_dac_code_b(o_dac_code_b),
    .o_dac_code_c(o_dac_code_c),
    .o_dac_code_d(o_dac_code_d),
    .o_gain_double(o_gain_double),
    .o_ref_input_pair_one_unbuf(o_ref_input_pair_one_unbuf),
    .o_ref_input_pair_two_unbuf(o_ref_input_pair_two_unbuf),
    .o_internal_ref_select(o_internal_ref_select),
    .o_power_down(o_power_down)
  );
  qdac_host_model u_host (.i_clk, .i_go(go), .o_load_strobe_n(i_dac_load_strobe_n));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // hang guard: the run needs well under a thousand cycles
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      end_sim();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // negative zero-volt temperatures go in as value plus 128, sign bit set
  function automatic logic [7:0] enc(int t);
    return (t < 0) ? (8'(t + 128) | 8'h80) : 8'(t);
  endfunction
  function automatic logic [11:0] therm(logic [9:0] t, logic [7:0] o, logic r);
    int d;
    d = $signed(t) - 4 * $signed(o);
    if (d < 0) return 12'h000;
    if (d > 1023) return 12'hfff;
    return r ? 12'(d * 4) : 12'(d / 4 * 16);
  endfunction
  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cyc(int n = 1);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic chk(logic [11:0] got, logic [11:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    i_reg_wr = 1'b1;
    i_reg_addr = a;
    i_reg_wdata = d;
    cyc();
    i_reg_wr = 1'b0;
    cyc();
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    i_reg_rd = 1'b1;
    i_reg_addr = a;
    cyc();
    i_reg_rd = 1'b0;
    chk({4'h0, o_reg_rdata}, {4'h0, e});
    cyc();
  endtask
  task automatic put_all(logic corner);
    for (int c = 0; c < 4; c++) begin
      inp[c] = corner ? {12{c[0]}} : 12'(xs());
      wr(8'(16 + 2 * c), inp[c][7:0]);
      wr(8'(17 + 2 * c), {4'h0, inp[c][11:8]});
    end
  endtask
  task automatic chk_all();
    chk(o_dac_code_a, act[0]);
    chk(o_dac_code_b, act[1]);
    chk(o_dac_code_c, act[2]);
    chk(o_dac_code_d, act[3]);
  endtask
  task automatic pulse();
    go = 1'b1;
    cyc();
    go = 1'b0;
    cyc(4);
  endtask
  initial begin
    {i_arst_n, i_reg_wr, i_reg_rd, go, i_reg_addr, i_reg_wdata} = '0;
    {i_temp_internal_valid, i_temp_external_valid} = 2'b00;
    {i_temp_internal, i_temp_external} = 20'h0;
    seed = 32'd81071;
    for (int c = 0; c < 4; c++) act[c] = 12'h000;
    cyc(10);
    i_arst_n = 1'b1;
    cyc();
    // every mapped register reads zero, gaps and unmapped places too
    for (int a = 16; a < 35; a++) rd(8'(a), 8'h00);
    rd(8'h30, 8'h00);
    // codes wait in the input stage until the strobe falls
    for (int k = 0; k < 3; k++) begin
      put_all(k == 0);
      rd(8'h14, act[2][7:0]);
      chk_all();
      pulse();
      act = inp;
      chk_all();
      rd(8'h17, {4'h0, act[3][11:8]});
    end
    // register load source: strobe ignored, pair and channel bits load
    wr(8'h1a, 8'h08);
    put_all(1'b0);
    pulse();
    chk_all();
    wr(8'h1b, 8'h10);
    act[0] = inp[0];
    act[1] = inp[1];
    chk_all();
    wr(8'h1c, 8'h0c);
    act[2] = inp[2];
    act[3] = inp[3];
    chk_all();
    put_all(1'b0);
    wr(8'h1b, 8'h20);
    act[2] = inp[2];
    act[3] = inp[3];
    chk_all();
    wr(8'h1c, 8'h03);
    act[0] = inp[0];
    act[1] = inp[1];
    chk_all();
    // analog controls follow the configuration bits
    for (int k = 0; k < 5; k++) begin
      v = (k == 0) ? 8'hff : 8'(xs());
      wr(8'h1b, v);
      wr(8'h1c, v);
      chk(12'(o_gain_double), 12'(v[3:0]));
      chk(12'({o_ref_input_pair_two_unbuf, o_ref_input_pair_one_unbuf}), 12'(v[7:6]));
      chk(12'({o_power_down, o_internal_ref_select}), 12'(v[5:4]));
    end
    wr(8'h1b, 8'h00);
    wr(8'h1c, 8'h00);
    wr(8'h21, enc(-40));
    wr(8'h22, enc(10));
    // thermal tracking of both channels at both resolutions
    for (int k = 0; k < 24; k++) begin
      h = k[0];
      wr(8'h1a, {6'b011010, h, 1'b0});
      i_temp_internal = (k == 0) ? 10'h000 : 10'(xs());
      i_temp_external = (k == 1) ? 10'h1ff : 10'(xs());
      {i_temp_internal_valid, i_temp_external_valid} = 2'b11;
      cyc();
      {i_temp_internal_valid, i_temp_external_valid} = 2'b00;
      cyc();
      chk(o_dac_code_a, therm(i_temp_internal, enc(-40), h));
      chk(o_dac_code_b, therm(i_temp_external, enc(10), h));
    end
    end_sim();
  end
endmodule
